// ---- verilog/sclk_params.svh ----
// constants of the serial command slave: characters, register map, timing
`ifndef SCLK_PARAMS_SVH
`define SCLK_PARAMS_SVH

// --------------------
// frame characters
// --------------------
`define SCLK_CH_STX 8'h02
`define SCLK_CH_ETX 8'h03
`define SCLK_CH_ACK 8'h06
`define SCLK_CH_NAK 8'h15
`define SCLK_CH_R 8'h52
`define SCLK_CH_W 8'h57
`define SCLK_CH_S 8'h53
`define SCLK_CH_V 8'h56
`define SCLK_CH_1 8'h31
`define SCLK_CH_L 8'h4c
`define SCLK_CH_O 8'h4f
`define SCLK_CH_C 8'h43
`define SCLK_CH_T 8'h54
`define SCLK_DIGIT_HI 4'h3
`define SCLK_DIGIT_MAX 4'h9
`define SCLK_EXC_MALFORMED 8'h31
`define SCLK_EXC_PROHIBITED 8'h32

// --------------------
// frame layout: body lengths and positions between start and end
// --------------------
`define SCLK_BODY_MAX 4'hc
`define SCLK_LEN_CMD 4'h6
`define SCLK_LEN_DATA 4'hb
`define SCLK_POS_REQ 2
`define SCLK_POS_CMD 3
`define SCLK_POS_DATA 6
`define SCLK_TX_NAK_LEN 4'h6
`define SCLK_TX_ACK_LEN 4'h5
`define SCLK_TX_READ_LEN 4'hd

// --------------------
// register map (byte addresses) and field positions
// --------------------
`define SCLK_A_CTRL 8'h00
`define SCLK_A_SLAVE 8'h04
`define SCLK_A_MON 8'h08
`define SCLK_A_KEYLOCK 8'h0c
`define SCLK_A_SETTEMP 8'h10
`define SCLK_A_NVTEMP 8'h14
`define SCLK_A_STATUS 8'h18
`define SCLK_A_IRQ_EN 8'h1c
`define SCLK_A_IRQ_CLR 8'h20
`define SCLK_A_STATE 8'h24
`define SCLK_B_SERIAL 0
`define SCLK_B_READ_ONLY 1
`define SCLK_B_ACT_LO 2
`define SCLK_B_RESTART 4
`define SCLK_EV_DONE 0
`define SCLK_EV_NAK 1
`define SCLK_EV_ALARM 2
`define SCLK_EV_STORE 3
`define SCLK_RST_SLAVE 16'h3031
`define SCLK_RST_KEYLOCK 20'h00000
`define SCLK_RST_SETTEMP 20'h00250

// --------------------
// timing: one second of the watchdog and the monitoring range
// --------------------
`define SCLK_CLK_PERIOD_NS 10
`define SCLK_SEC_NS 1000000000
`define SCLK_MON_MIN 10'h01e
`define SCLK_MON_MAX 10'h258
`define SCLK_MON_DEF 10'h01e

`endif

// ---- verilog/sclk_pkg.sv ----
// types of the serial command slave
package sclk_pkg;

   // --------------------
   // link watchdog action setting
   // --------------------
   typedef enum logic [1:0] {
      SCLK_ACT_OFF = 2'b00,
      SCLK_ACT_CONTINUE = 2'b01,
      SCLK_ACT_STOP = 2'b10
   } sclk_action_t;

   // --------------------
   // frame sequencer states
   // --------------------
   typedef enum logic [2:0] {
      SCLK_ST_IDLE = 3'b000,
      SCLK_ST_BODY = 3'b001,
      SCLK_ST_BCC = 3'b010,
      SCLK_ST_EXEC = 3'b011,
      SCLK_ST_SEND = 3'b100
   } sclk_state_t;

   // --------------------
   // state of the watchdog
   // --------------------
   typedef struct packed {
      logic [26:0] tick_cnt;
      logic [9:0] sec_cnt;
      logic alarm;
   } sclk_wdog_t;

   // --------------------
   // state of the command interpreter
   // --------------------
   typedef struct packed {
      sclk_state_t state;
      logic [11:0][7:0] rx_buf;
      logic [3:0] rx_cnt;
      logic rx_ovf;
      logic [12:0][7:0] tx_buf;
      logic [3:0] tx_len;
      logic serial_mode;
      logic read_only_range;
      sclk_action_t action;
      logic [15:0] slave_addr;
      logic [9:0] mon_time;
      logic [19:0] key_lock;
      logic [19:0] set_temp;
      logic [19:0] nv_temp;
      logic nv_store;
      logic [3:0] status;
      logic [3:0] irq_en;
      logic [31:0] prdata;
      logic pslverr;
      logic halted;
      logic alarm_prev;
   } sclk_core_t;

endpackage

// ---- verilog/sclk_wdog.sv ----
// link watchdog: counts whole seconds since the last message addressed to this slave, refused or not
`include "sclk_params.svh"

module sclk_wdog #(
   parameter int unsigned SEC_CYCLES = `SCLK_SEC_NS / `SCLK_CLK_PERIOD_NS
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_enable,
   input wire logic i_msg,
   input wire logic [9:0] i_mon_time,
   output logic o_alarm
);

   sclk_pkg::sclk_wdog_t s_q;
   sclk_pkg::sclk_wdog_t s_d;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // disabled or fed: counts restart and the alarm drops at once
   always_comb begin
      s_d = s_q;
      if (!i_enable || i_msg) begin
         s_d.tick_cnt = '0;
         s_d.sec_cnt = '0;
         s_d.alarm = 1'b0;
      end else begin
         if (s_q.tick_cnt == 27'(SEC_CYCLES - 1)) begin
            s_d.tick_cnt = '0;
            if (s_q.sec_cnt < i_mon_time) begin
               s_d.sec_cnt = s_q.sec_cnt + 10'h001;
            end
         end else begin
            s_d.tick_cnt = s_q.tick_cnt + 27'h0000001;
         end
         if (s_q.sec_cnt >= i_mon_time) begin
            s_d.alarm = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_alarm = s_q.alarm;

endmodule

// ---- verilog/sclk_core.sv ----
// serial command slave: framed key-lock, set temperature, store, link watchdog
//
// Function
// - link key-lock value kept apart from panel
// - key-lock write only stored, never locks keys
// - key-lock read echoes ack, command, five digits
// - accepted write answers start, address, ack, end
// - store command saves set temperature to memory
// - store never saves the link key-lock value
// - malformed or refused request gets negative response
// - negative response carries code; read-only gives 2
// - watchdog works only in serial mode
// - watchdog action is off after reset
// - alarm once silence exceeds monitoring time seconds
// - alarm clears itself when a message arrives
// - action setting is off, continue or stop
// - monitoring time 30 to 600 s, default 30
// - monitoring time hidden while action is off
// - stop halt persists until a restart
// - set temperature writable only in serial mode; the APB register takes writes in any mode
//
// Our own choices: register access over APB and the address map.
`include "sclk_params.svh"

module sclk_core #(
   parameter int unsigned SEC_CYCLES = `SCLK_SEC_NS / `SCLK_CLK_PERIOD_NS
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   output logic o_tx_last,
   input wire logic i_tx_ready,
   output logic o_nv_store,
   output logic [19:0] o_nv_temp,
   output logic [19:0] o_set_temp,
   output logic o_link_alarm,
   output logic o_run_enable,
   output logic o_irq
);

   sclk_pkg::sclk_core_t s_q;
   sclk_pkg::sclk_core_t s_d;
   logic wd_alarm;
   logic msg_seen;
   logic wd_enable;

   // --------------------
   // link watchdog
   // --------------------
   // only runs in serial mode with an action other than off
   assign wd_enable = s_q.serial_mode && (s_q.action != sclk_pkg::SCLK_ACT_OFF);

   sclk_wdog #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_wdog (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_enable(wd_enable),
      .i_msg(msg_seen),
      .i_mon_time(s_q.mon_time),
      .o_alarm(wd_alarm)
   );

   // --------------------
   // next state
   // --------------------
   always_comb begin
      logic setup;
      logic wr;
      logic addr_ok;
      logic is_temp_cmd;
      logic is_lock_cmd;
      logic is_store_cmd;
      logic data_ok;
      logic nak;
      logic ack_read;
      logic [7:0] code;
      logic [19:0] wval;
      logic [19:0] rval;
      logic [3:0] ev;
      logic [3:0] clr;
      setup = i_psel && !i_penable;
      wr = i_psel && i_penable && i_pwrite;
      addr_ok = 1'b0;
      is_temp_cmd = 1'b0;
      is_lock_cmd = 1'b0;
      is_store_cmd = 1'b0;
      data_ok = 1'b1;
      nak = 1'b1;
      ack_read = 1'b0;
      code = `SCLK_EXC_MALFORMED;
      wval = '0;
      rval = '0;
      ev = '0;
      clr = '0;
      msg_seen = 1'b0;
      s_d = s_q;
      s_d.nv_store = 1'b0;

      // frame sequencer
      unique case (s_q.state)
         sclk_pkg::SCLK_ST_IDLE: begin
            if (i_rx_valid && i_rx_data == `SCLK_CH_STX) begin
               s_d.rx_cnt = '0;
               s_d.rx_ovf = 1'b0;
               s_d.state = sclk_pkg::SCLK_ST_BODY;
            end
         end
         sclk_pkg::SCLK_ST_BODY: begin
            if (i_rx_valid) begin
               if (i_rx_data == `SCLK_CH_STX) begin
                  s_d.rx_cnt = '0; // a new start drops the partial frame
                  s_d.rx_ovf = 1'b0;
               end else if (i_rx_data == `SCLK_CH_ETX) begin
                  s_d.state = sclk_pkg::SCLK_ST_BCC;
               end else if (s_q.rx_cnt < `SCLK_BODY_MAX) begin
                  s_d.rx_buf[s_q.rx_cnt] = i_rx_data;
                  s_d.rx_cnt = s_q.rx_cnt + 4'h1;
               end else begin
                  s_d.rx_ovf = 1'b1;
               end
            end
         end
         sclk_pkg::SCLK_ST_BCC: begin
            // the check character is verified outside; it only closes the frame
            if (i_rx_valid) begin
               s_d.state = sclk_pkg::SCLK_ST_EXEC;
            end
         end
         sclk_pkg::SCLK_ST_EXEC: begin
            addr_ok = s_q.rx_buf[0] == s_q.slave_addr[15:8]
               && s_q.rx_buf[1] == s_q.slave_addr[7:0];
            is_temp_cmd = s_q.rx_buf[`SCLK_POS_CMD] == `SCLK_CH_S
               && s_q.rx_buf[`SCLK_POS_CMD + 1] == `SCLK_CH_V
               && s_q.rx_buf[`SCLK_POS_CMD + 2] == `SCLK_CH_1;
            is_lock_cmd = s_q.rx_buf[`SCLK_POS_CMD] == `SCLK_CH_L
               && s_q.rx_buf[`SCLK_POS_CMD + 1] == `SCLK_CH_O
               && s_q.rx_buf[`SCLK_POS_CMD + 2] == `SCLK_CH_C;
            is_store_cmd = s_q.rx_buf[`SCLK_POS_CMD] == `SCLK_CH_S
               && s_q.rx_buf[`SCLK_POS_CMD + 1] == `SCLK_CH_T
               && s_q.rx_buf[`SCLK_POS_CMD + 2] == `SCLK_CH_R;
            // data field: five ascii digits, first digit most significant
            for (int i = 0; i < 5; i++) begin
               if (s_q.rx_buf[`SCLK_POS_DATA + i][7:4] != `SCLK_DIGIT_HI
                  || s_q.rx_buf[`SCLK_POS_DATA + i][3:0] > `SCLK_DIGIT_MAX) begin
                  data_ok = 1'b0;
               end
               wval[19 - 4 * i -: 4] = s_q.rx_buf[`SCLK_POS_DATA + i][3:0];
            end
            if (s_q.rx_ovf) begin
               nak = 1'b1;
            end else if (s_q.rx_buf[`SCLK_POS_REQ] == `SCLK_CH_R
               && s_q.rx_cnt == `SCLK_LEN_CMD) begin
               if (is_temp_cmd) begin
                  nak = 1'b0;
                  ack_read = 1'b1;
                  rval = s_q.set_temp;
               end else if (is_lock_cmd) begin
                  nak = 1'b0;
                  ack_read = 1'b1;
                  rval = s_q.key_lock;
               end
            end else if (s_q.rx_buf[`SCLK_POS_REQ] == `SCLK_CH_W) begin
               if (s_q.read_only_range && (is_temp_cmd || is_lock_cmd || is_store_cmd)) begin
                  code = `SCLK_EXC_PROHIBITED;
               end else if (is_temp_cmd && s_q.rx_cnt == `SCLK_LEN_DATA && data_ok) begin
                  if (!s_q.serial_mode) begin
                     code = `SCLK_EXC_PROHIBITED;
                  end else begin
                     nak = 1'b0;
                     s_d.set_temp = wval;
                  end
               end else if (is_lock_cmd && s_q.rx_cnt == `SCLK_LEN_DATA && data_ok) begin
                  nak = 1'b0;
                  s_d.key_lock = wval;
               end else if (is_store_cmd && s_q.rx_cnt == `SCLK_LEN_CMD) begin
                  nak = 1'b0;
                  s_d.nv_temp = s_q.set_temp;
                  s_d.nv_store = 1'b1;
                  ev[`SCLK_EV_STORE] = 1'b1;
               end
            end
            // answer: start and own address always lead
            s_d.tx_buf = '0;
            s_d.tx_buf[0] = `SCLK_CH_STX;
            s_d.tx_buf[1] = s_q.slave_addr[15:8];
            s_d.tx_buf[2] = s_q.slave_addr[7:0];
            if (nak) begin
               s_d.tx_buf[3] = `SCLK_CH_NAK;
               s_d.tx_buf[4] = code;
               s_d.tx_buf[5] = `SCLK_CH_ETX;
               s_d.tx_len = `SCLK_TX_NAK_LEN;
            end else if (ack_read) begin
               s_d.tx_buf[3] = `SCLK_CH_ACK;
               s_d.tx_buf[4] = s_q.rx_buf[`SCLK_POS_CMD];
               s_d.tx_buf[5] = s_q.rx_buf[`SCLK_POS_CMD + 1];
               s_d.tx_buf[6] = s_q.rx_buf[`SCLK_POS_CMD + 2];
               for (int i = 0; i < 5; i++) begin
                  s_d.tx_buf[7 + i] = {`SCLK_DIGIT_HI, rval[19 - 4 * i -: 4]};
               end
               s_d.tx_buf[12] = `SCLK_CH_ETX;
               s_d.tx_len = `SCLK_TX_READ_LEN;
            end else begin
               s_d.tx_buf[3] = `SCLK_CH_ACK;
               s_d.tx_buf[4] = `SCLK_CH_ETX;
               s_d.tx_len = `SCLK_TX_ACK_LEN;
            end
            if (addr_ok) begin
               msg_seen = 1'b1;
               ev[`SCLK_EV_DONE] = 1'b1;
               ev[`SCLK_EV_NAK] = nak;
               s_d.state = sclk_pkg::SCLK_ST_SEND;
            end else begin
               // foreign frame: no effect at all, no answer
               s_d.set_temp = s_q.set_temp;
               s_d.key_lock = s_q.key_lock;
               s_d.nv_temp = s_q.nv_temp;
               s_d.nv_store = 1'b0;
               ev = '0;
               s_d.state = sclk_pkg::SCLK_ST_IDLE;
            end
         end
         sclk_pkg::SCLK_ST_SEND: begin
            // characters arriving while answering are dropped
            if (i_tx_ready) begin
               s_d.tx_buf = {8'h00, s_q.tx_buf[12:1]};
               s_d.tx_len = s_q.tx_len - 4'h1;
               if (s_q.tx_len == 4'h1) begin
                  s_d.state = sclk_pkg::SCLK_ST_IDLE;
               end
            end
         end
         default: begin
            s_d.state = sclk_pkg::SCLK_ST_IDLE;
         end
      endcase

      // alarm edge: event bit, and a halt when the action is stop
      s_d.alarm_prev = wd_alarm;
      if (wd_alarm && !s_q.alarm_prev) begin
         ev[`SCLK_EV_ALARM] = 1'b1;
         if (s_q.action == sclk_pkg::SCLK_ACT_STOP) begin
            s_d.halted = 1'b1;
         end
      end

      // apb writes take effect in the access phase
      if (wr) begin
         unique case (i_paddr)
            `SCLK_A_CTRL: begin
               s_d.serial_mode = i_pwdata[`SCLK_B_SERIAL];
               s_d.read_only_range = i_pwdata[`SCLK_B_READ_ONLY];
               if (i_pwdata[`SCLK_B_ACT_LO + 1 -: 2] != 2'b11) begin
                  s_d.action = sclk_pkg::sclk_action_t'(i_pwdata[`SCLK_B_ACT_LO + 1 -: 2]);
               end
               if (i_pwdata[`SCLK_B_RESTART] && !ev[`SCLK_EV_ALARM]) begin
                  s_d.halted = 1'b0;
               end
            end
            `SCLK_A_SLAVE: s_d.slave_addr = i_pwdata[15:0];
            `SCLK_A_MON: begin
               if (s_q.action != sclk_pkg::SCLK_ACT_OFF
                  && i_pwdata[9:0] >= `SCLK_MON_MIN && i_pwdata[9:0] <= `SCLK_MON_MAX
                  && i_pwdata[31:10] == '0) begin
                  s_d.mon_time = i_pwdata[9:0];
               end
            end
            `SCLK_A_SETTEMP: s_d.set_temp = i_pwdata[19:0];
            `SCLK_A_IRQ_EN: s_d.irq_en = i_pwdata[3:0];
            `SCLK_A_IRQ_CLR: clr = i_pwdata[3:0];
            default: begin
            end
         endcase
      end

      // sticky status: a new event wins over a clear in the same cycle
      s_d.status = (s_q.status & ~clr) | ev;

      // apb read data and error are captured in the setup phase
      if (setup) begin
         s_d.prdata = '0;
         s_d.pslverr = 1'b0;
         unique case (i_paddr)
            `SCLK_A_CTRL: begin
               s_d.prdata[`SCLK_B_SERIAL] = s_q.serial_mode;
               s_d.prdata[`SCLK_B_READ_ONLY] = s_q.read_only_range;
               s_d.prdata[`SCLK_B_ACT_LO + 1 -: 2] = s_q.action;
            end
            `SCLK_A_SLAVE: s_d.prdata[15:0] = s_q.slave_addr;
            `SCLK_A_MON: begin
               if (s_q.action != sclk_pkg::SCLK_ACT_OFF) begin
                  s_d.prdata[9:0] = s_q.mon_time;
               end
            end
            `SCLK_A_KEYLOCK: s_d.prdata[19:0] = s_q.key_lock;
            `SCLK_A_SETTEMP: s_d.prdata[19:0] = s_q.set_temp;
            `SCLK_A_NVTEMP: s_d.prdata[19:0] = s_q.nv_temp;
            `SCLK_A_STATUS: s_d.prdata[3:0] = s_q.status;
            `SCLK_A_IRQ_EN: s_d.prdata[3:0] = s_q.irq_en;
            `SCLK_A_IRQ_CLR: s_d.prdata = '0;
            `SCLK_A_STATE: s_d.prdata[2:0] = {s_q.state != sclk_pkg::SCLK_ST_IDLE,
               s_q.halted, s_q.alarm_prev};
            default: s_d.pslverr = 1'b1;
         endcase
      end
   end

   // --------------------
   // state register
   // --------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         s_q <= '0;
         s_q.action <= sclk_pkg::SCLK_ACT_OFF;
         s_q.slave_addr <= `SCLK_RST_SLAVE;
         s_q.mon_time <= `SCLK_MON_DEF;
         s_q.key_lock <= `SCLK_RST_KEYLOCK;
         s_q.set_temp <= `SCLK_RST_SETTEMP;
         s_q.nv_temp <= `SCLK_RST_SETTEMP;
      end else begin
         s_q <= s_d;
      end
   end

   // --------------------
   // outputs
   // --------------------
   assign o_prdata = s_q.prdata;
   assign o_pready = 1'b1; // zero wait states
   assign o_pslverr = s_q.pslverr && i_psel && i_penable;
   assign o_tx_valid = s_q.state == sclk_pkg::SCLK_ST_SEND;
   assign o_tx_data = s_q.tx_buf[0];
   assign o_tx_last = s_q.tx_len == 4'h1;
   assign o_nv_store = s_q.nv_store;
   assign o_nv_temp = s_q.nv_temp;
   assign o_set_temp = s_q.set_temp;
   assign o_link_alarm = s_q.alarm_prev;
   assign o_run_enable = !s_q.halted;
   assign o_irq = |(s_q.status & s_q.irq_en);

endmodule

// ---- verification/sclk_core_assertions.sv ----
// checker of the serial command slave
module sclk_core_chk #(
   parameter int unsigned SEC_CYCLES = 10
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic i_tx_ready,
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic o_tx_last,
   input wire logic o_nv_store,
   input wire logic [19:0] o_nv_temp,
   input wire logic [19:0] o_set_temp,
   input wire logic o_link_alarm,
   input wire logic o_run_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ctrl_wr;
   logic restart_wr;
   // --------------------
   // control writes, the only legal cause of a cleared halt
   // --------------------
   assign ctrl_wr = i_psel && i_penable && i_pwrite && i_paddr == 8'h00;
   assign restart_wr = ctrl_wr && i_pwdata[4];
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // --------------------
   // properties
   // --------------------
   tx_start_a: assert property ($rose(o_tx_valid) |-> o_tx_data == 8'h02)
      else $error("answer does not open with the start character");
   tx_last_a: assert property (o_tx_last |-> o_tx_valid && o_tx_data == 8'h03)
      else $error("last flag away from the end character");
   tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> $stable(o_tx_data))
      else $error("answer character changed while stalled");
   tx_end_a: assert property (o_tx_last && i_tx_ready |=> !o_tx_valid)
      else $error("answer goes on after the end character");
   nv_copy_a: assert property ($changed(o_nv_temp) |-> o_nv_store && o_nv_temp == $past(o_set_temp))
      else $error("stored value is not the set temperature");
   alarm_clear_a: assert property ($fell(o_link_alarm) && !$past(ctrl_wr, 3) |-> $past(o_tx_valid))
      else $error("alarm cleared without a message");
   alarm_quiet_a: assert property ($rose(o_link_alarm) |-> !o_tx_valid)
      else $error("alarm raised right after a message");
   halt_cause_a: assert property ($fell(o_run_enable) |-> ##[0:2] o_link_alarm)
      else $error("operation halted without an alarm");
   halt_keep_a: assert property (!o_run_enable && !restart_wr |=> !o_run_enable)
      else $error("halt ended without a restart");
   cover property ($rose(o_tx_valid));
   cover property ($fell(o_link_alarm));
   cover property ($fell(o_run_enable));
   cover property ($rose(o_run_enable));
endmodule

// ---- verification/sclk_host.sv ----
// serial master model: sends framed requests and collects the answer characters
module sclk_host (
   input wire logic i_ref_clk,
   input wire logic i_slow,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic o_tx_ready,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_last
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   logic done;
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
      o_tx_ready = 1'b1;
      done = 1'b0;
   end
   // consumer: takes answer characters, stalls every other cycle when slow
   always @(posedge i_ref_clk) begin
      if (i_tx_valid && o_tx_ready) begin
         q.push_back(i_tx_data);
         if (i_tx_last) done <= 1'b1;
      end
      o_tx_ready <= !i_slow || !o_tx_ready;
   end
   // one request per call, the bench spaces them as its traffic pattern
   task automatic send(input string body);
      string f;
      f = {"\002", body, "\003 "};
      q.delete();
      done = 1'b0;
      for (int i = 0; i < f.len(); i++) begin
         o_rx_valid <= 1'b1;
         o_rx_data <= f[i];
         @(posedge i_ref_clk);
      end
      o_rx_valid <= 1'b0;
      o_rx_data <= ~f[f.len()-1]; // idle line shows no stale character
   endtask
endmodule

// ---- verification/testbench.sv ----
// testbench of the serial command slave
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned SEC = 10;
   localparam string ACK = "\00201\006\003";
   localparam string NAK2 = "\00201\0252\003";
   localparam string LOCRD = "\00201\006LOC00001\003";
   logic clk, rst, psel, penable, pwrite, pready, pslverr, last_err, slow;
   logic rx_valid, tx_valid, tx_last, tx_ready, nv_store, alarm, run_en, irq;
   logic [7:0] paddr, rx_data, tx_data;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] nv_temp, set_temp;
   int n_errors = 0;
   int checks_done = 0;
   int n;
   sclk_core #(.SEC_CYCLES(SEC)) i_dut (
      .i_ref_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
      .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last),
      .i_tx_ready(tx_ready), .o_nv_store(nv_store), .o_nv_temp(nv_temp),
      .o_set_temp(set_temp), .o_link_alarm(alarm), .o_run_enable(run_en), .o_irq(irq));
   sclk_host i_host (
      .i_ref_clk(clk), .i_slow(slow), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
      .o_tx_ready(tx_ready), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
      .i_tx_last(tx_last));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // --------------------
   // comparison, verdict and bus tasks
   // --------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic hang();
      check("wait bound", 32'h0, 32'h1);
      close_out();
   endtask
   // one apb transfer: setup, access held until pready at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) hang();
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk); // one idle edge between transfers
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check($sformatf("register %h", a), rd, e);
   endtask
   // one request frame and the full answer, empty when none is due
   task automatic xfer(input string body, input string exp);
      int k;
      k = 0;
      i_host.send(body);
      while (i_host.done !== 1'b1 && k < 100) begin
         @(posedge clk);
         k++;
      end
      if (k == 100 && exp.len() != 0) hang();
      @(posedge clk);
      check("answer length", 32'(i_host.q.size()), 32'(exp.len()));
      for (int i = 0; i < exp.len(); i++) check("answer char", 32'(i_host.q[i]), 32'(exp[i]));
   endtask
   task automatic wait_alarm(output int c);
      c = 0;
      while (alarm !== 1'b1 && c < 2000) begin
         @(posedge clk);
         c++;
      end
      if (alarm !== 1'b1) hang();
   endtask
   // --------------------
   // main sequence
   // --------------------
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, slow} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h00, 32'h0);
      rdc(8'h04, 32'h3031);
      rdc(8'h08, 32'h0);
      rdc(8'h10, 32'h250);
      apb(1'b0, 8'h28, 32'h0);
      check("unmapped error", 32'(last_err), 32'h1);
      apb(1'b1, 8'h08, 32'h64);
      rdc(8'h08, 32'h0);
      $display("test registers done");
      xfer("01WLOC00001", ACK);
      rdc(8'h0c, 32'h1);
      check("run enable", 32'(run_en), 32'h1);
      slow <= 1'b1;
      xfer("01RLOC", LOCRD);
      slow <= 1'b0;
      xfer("02RLOC", "");
      $display("test key lock done");
      xfer("01WSV100358", NAK2);
      apb(1'b1, 8'h00, 32'h1);
      xfer("01WSV100358", ACK);
      check("set temp", 32'(set_temp), 32'h358);
      xfer("01WSTR", ACK);
      rdc(8'h14, 32'h358);
      check("irq masked", 32'(irq), 32'h0);
      apb(1'b1, 8'h1c, 32'h8);
      @(posedge clk);
      check("irq raised", 32'(irq), 32'h1);
      apb(1'b1, 8'h20, 32'h8);
      @(posedge clk);
      check("irq cleared", 32'(irq), 32'h0);
      rdc(8'h18, 32'h3);
      apb(1'b1, 8'h00, 32'h3);
      xfer("01WSV100200", NAK2);
      xfer("01WXYZ", "\00201\0251\003");
      $display("test commands done");
      apb(1'b1, 8'h00, 32'h1);
      repeat (400) @(posedge clk);
      check("alarm off", 32'(alarm), 32'h0);
      apb(1'b1, 8'h00, 32'h4);
      apb(1'b1, 8'h08, 32'd29);
      rdc(8'h08, 32'd30);
      apb(1'b1, 8'h08, 32'd601);
      rdc(8'h08, 32'd30);
      apb(1'b1, 8'h08, 32'd600);
      rdc(8'h08, 32'd600);
      apb(1'b1, 8'h08, 32'd30);
      repeat (400) @(posedge clk);
      check("alarm not serial", 32'(alarm), 32'h0);
      apb(1'b1, 8'h00, 32'hc);
      rdc(8'h00, 32'h4);
      apb(1'b1, 8'h00, 32'h5);
      xfer("01RLOC", LOCRD);
      wait_alarm(n);
      check("alarm time", 32'(n > 270 && n < 305), 32'h1);
      check("run continues", 32'(run_en), 32'h1);
      xfer("01RLOC", LOCRD);
      check("alarm cleared", 32'(alarm), 32'h0);
      apb(1'b1, 8'h00, 32'h9);
      wait_alarm(n);
      repeat (3) @(posedge clk);
      check("run halted", 32'(run_en), 32'h0);
      rdc(8'h24, 32'h3);
      xfer("01RLOC", LOCRD);
      check("alarm cleared", 32'(alarm), 32'h0);
      check("halt kept", 32'(run_en), 32'h0);
      apb(1'b1, 8'h00, 32'h19);
      @(posedge clk);
      check("restarted", 32'(run_en), 32'h1);
      $display("test watchdog done");
      close_out();
   end
endmodule
bind sclk_core sclk_core_chk #(.SEC_CYCLES(SEC_CYCLES)) i_chk (
   .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_tx_ready(i_tx_ready),
   .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last),
   .o_nv_store(o_nv_store), .o_nv_temp(o_nv_temp), .o_set_temp(o_set_temp),
   .o_link_alarm(o_link_alarm), .o_run_enable(o_run_enable));
